// >>> hw/adcc_pkg.sv
package adcc_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_RES_LOW     = 4'h1;
  localparam logic [3:0] ADDR_RES_HIGH    = 4'h2;
  localparam logic [3:0] ADDR_TRIG_POL    = 4'h3;
  localparam logic [3:0] ADDR_DIS_LOW     = 4'h4;
  localparam logic [3:0] ADDR_DIS_HIGH    = 4'h5;
  localparam logic [3:0] ADDR_MISC        = 4'h6;
  localparam logic [3:0] ADDR_MUX_CFG     = 4'h7;

  // Register field positions.
  localparam int CS_ENABLE  = 7;
  localparam int CS_START   = 6;
  localparam int CS_AUTO    = 5;
  localparam int CS_DONE    = 4;
  localparam int CS_IRQ_EN  = 3;
  localparam int TP_BIPOLAR = 7;
  localparam int MC_LEFT    = 5;
  localparam int MS_EXTREF  = 2;
  localparam int MS_REFOUT  = 1;
  localparam int MS_ISRC    = 0;

  // Writable bit masks; everything else reads zero.
  localparam logic [7:0] TP_WMASK  = 8'hf7;
  localparam logic [7:0] DH_WMASK  = 8'h70;
  localparam logic [7:0] MS_WMASK  = 8'h07;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // Conversion lengths in converter clocks.
  localparam logic [4:0] FIRST_CONV_CLKS = 5'd25;
  localparam logic [4:0] NORM_CONV_CLKS  = 5'd13;

  localparam logic [2:0] TRIG_FREE = 3'h0;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_CONV = 2'b01
  } adcc_state_t;

  // Avalon-MM request carried as one bundle.
  typedef struct packed {
    logic       read;
    logic       write;
    logic [3:0] address;
    logic [7:0] writedata;
  } adcc_req_t;

endpackage

// >>> hw/adcc_top.sv
// Notes on behaviour
// R1 - Auto-trigger starts conversion on selected rising edge.
// R2 - Done flag sets when result registers update.
// R3 - Interrupt needs flag, enable and global enable.
// R4 - Flag clears on vector taken or written one.
// R5 - Prescaler codes divide by 2,2,4..128.
// R6 - Right adjust bits 9:0, left bits 15:6.
// R7 - Low byte read locks result until high read.
// R8 - Software reads low byte before high byte.
// R9 - Unipolar saturates; bipolar gives two's complement.
// R10 - Unipolar 10 bits; bipolar 9 plus sign.
// R11 - Trigger source used only when auto-trigger set.
// R12 - Source switch clear-to-set counts as rising edge.
// R13 - Switching to free running never triggers.
// R14 - Source codes map to the eight trigger flags. Code 0 selects free running instead, so only codes 1..7 use flags 1..7.
// R15 - Reserved bits read as zero.
// R16 - Low disable bits zero matching port inputs.
// R17 - High disable bits 6..4 zero pins 10..8.
// R18 - External reference enable selects reference pin.
// R19 - Reference output enable drives internal reference out.
// R20 - Start bit busy; first conversion 25 clocks, else 13.
// R21 - Enable powers converter; clearing aborts conversion.
// R22 - Trigger edges by registered compare, one start each.
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module adcc_top (
  input  wire logic                core_clk,       // System clock.
  input  wire logic                rst_n,          // Sync reset, low.
  input  wire logic [3:0]          avs_address,    // Register address.
  input  wire logic                avs_read,       // Read strobe.
  input  wire logic                avs_write,      // Write strobe.
  input  wire logic [7:0]          avs_writedata,  // Write data.
  output logic [7:0]               avs_readdata,   // Read data.
  output logic                     avs_waitrequest, // Stall.
  input  wire logic [7:0]          trig_flags,     // Trigger flags 0..7.
  input  wire logic                global_irq_en,  // Global enable bit.
  input  wire logic                irq_ack,        // Vector taken pulse.
  output logic                     irq_req,        // Interrupt request.
  output logic                     conv_sample,    // Core sample pulse.
  output logic                     conv_clk_en,    // Converter clock tick.
  input  wire logic [9:0]          core_data,      // Raw core result.
  input  wire logic                core_negative,  // Pos not above neg.
  input  wire logic [10:0]         pin_in,         // Raw pin inputs.
  output logic [10:0]              pin_in_gated,   // Port input bits.
  output logic                     ext_ref_sel,    // Reference from pin.
  output logic                     ref_out_en,     // Drive ref out pin.
  output logic                     isrc_en,        // Current source on.
  output logic                     conv_power      // Converter powered.
);
  import adcc_pkg::*;

  logic [7:0]  cs_ff, nxt_cs;
  logic [7:0]  tp_ff, dl_ff, dh_ff, ms_ff, mx_ff;
  logic [9:0]  res_ff;
  logic        lock_ff;
  logic [6:0]  pre_ff;
  logic [4:0]  cnt_ff;
  logic        first_ff;
  logic        trig_ff;
  logic        ack_ff;
  logic        done_prev_ff;
  logic [10:0] pin_s1_ff, pin_s2_ff;
  adcc_state_t st_ff;
  adcc_req_t   req;

  assign req = '{read: avs_read, write: avs_write,
                 address: avs_address, writedata: avs_writedata};

  // Registers answer in the cycle of the request, no stall.
  assign avs_waitrequest = 1'b0;

  // Write and read decode.
  wire wr_cs = req.write && req.address == ADDR_CTRL_STATUS;
  wire wr_tp = req.write && req.address == ADDR_TRIG_POL;
  wire wr_dl = req.write && req.address == ADDR_DIS_LOW;
  wire wr_dh = req.write && req.address == ADDR_DIS_HIGH;
  wire wr_ms = req.write && req.address == ADDR_MISC;
  wire wr_mx = req.write && req.address == ADDR_MUX_CFG;
  wire rd_lo = req.read && req.address == ADDR_RES_LOW;
  wire rd_hi = req.read && req.address == ADDR_RES_HIGH;

  wire enable  = cs_ff[CS_ENABLE];
  wire auto_on = cs_ff[CS_AUTO];
  wire [2:0] psel = cs_ff[2:0];
  wire [2:0] tsel = tp_ff[2:0];

  // Prescaler: a counter held at zero while idle whose bit picks the tick rate.
  wire [7:0] pre_nxt = {1'b0, pre_ff} + 8'h01;
  wire [2:0] pre_bit = (psel == 3'h0) ? 3'h0 : 3'(psel - 3'h1); // R5
  wire [7:0] pre_mask = 8'((8'h01 << pre_bit) << 1) - 8'h01;
  assign conv_clk_en = enable && ((pre_ff & pre_mask[6:0]) ==
                        pre_mask[6:0]); // R5

  // Trigger selection; free running follows the done flag itself.
  wire src_raw = (tsel == TRIG_FREE) ? 1'b0 : trig_flags[tsel]; // R14
  wire trig_edge = src_raw && !trig_ff; // R22 R12 R13
  // Free running restarts on the rise of the done flag only, so that
  // selecting source zero while the flag already stands starts nothing.
  wire free_go = (tsel == TRIG_FREE) && cs_ff[CS_DONE] &&
                 !done_prev_ff; // R13
  wire auto_go = auto_on && enable && (trig_edge || free_go); // R1 R11
  wire sw_go = wr_cs && req.writedata[CS_START] &&
               req.writedata[CS_ENABLE];
  wire go = (sw_go || auto_go) && st_ff == ADCC_IDLE;

  // Conversion finishes on the last converter clock.
  wire conv_end = st_ff == ADCC_CONV && conv_clk_en && cnt_ff == 5'd1;
  wire abort = wr_cs && !req.writedata[CS_ENABLE]; // R21

  // Result formatting: saturate in unipolar, keep sign in bipolar.
  wire bip = tp_ff[TP_BIPOLAR];
  wire [9:0] conv_val = (!bip && core_negative) ? 10'h3ff : core_data; // R9 R10
  wire left = mx_ff[MC_LEFT];
  wire [15:0] res16 = left ? {res_ff, 6'h00} : {6'h00, res_ff}; // R6

  // Control/status next value.
  always_comb begin
    nxt_cs = cs_ff;
    if (wr_cs) begin
      nxt_cs[7:5] = req.writedata[7:5];
      nxt_cs[3:0] = req.writedata[3:0];
      nxt_cs[CS_START] = cs_ff[CS_START] | req.writedata[CS_START];
      if (req.writedata[CS_DONE]) begin
        nxt_cs[CS_DONE] = 1'b0; // R4
      end
    end
    if (ack_ff) begin
      nxt_cs[CS_DONE] = 1'b0; // R4
    end
    if (go) begin
      nxt_cs[CS_START] = 1'b1; // R20
    end
    if (conv_end) begin
      nxt_cs[CS_START] = 1'b0; // R20
      nxt_cs[CS_DONE] = 1'b1; // R2
    end
    if (abort || !nxt_cs[CS_ENABLE]) begin
      nxt_cs[CS_START] = 1'b0; // R21
    end
  end

  // Register file and reset state.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cs_ff <= RESET_VAL;
      tp_ff <= RESET_VAL;
      dl_ff <= RESET_VAL;
      dh_ff <= RESET_VAL;
      ms_ff <= RESET_VAL;
      mx_ff <= RESET_VAL;
    end else begin
      cs_ff <= nxt_cs;
      if (wr_tp) tp_ff <= req.writedata & TP_WMASK; // R15
      if (wr_dl) dl_ff <= req.writedata;
      if (wr_dh) dh_ff <= req.writedata & DH_WMASK; // R15
      if (wr_ms) ms_ff <= req.writedata & MS_WMASK; // R15
      if (wr_mx) mx_ff <= req.writedata;
    end
  end

  // Conversion sequencer with first-conversion length.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff    <= ADCC_IDLE;
      cnt_ff   <= 5'd0;
      first_ff <= 1'b1;
      pre_ff   <= 7'h00;
    end else begin
      pre_ff <= (st_ff == ADCC_IDLE && !go) ? 7'h00 : pre_nxt[6:0];
      if (!nxt_cs[CS_ENABLE]) begin
        st_ff    <= ADCC_IDLE; // R21
        first_ff <= 1'b1;
      end else if (go) begin
        st_ff  <= ADCC_CONV;
        cnt_ff <= first_ff ? FIRST_CONV_CLKS : NORM_CONV_CLKS; // R20
      end else if (conv_end) begin
        st_ff    <= ADCC_IDLE;
        first_ff <= 1'b0;
      end else if (st_ff == ADCC_CONV && conv_clk_en) begin
        cnt_ff <= cnt_ff - 5'd1;
      end
    end
  end

  // Result lock: reading low byte freezes until high byte read.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      res_ff  <= 10'h000;
      lock_ff <= 1'b0;
    end else begin
      if (conv_end && !lock_ff) begin
        res_ff <= conv_val; // R7
      end
      if (rd_hi) begin
        lock_ff <= 1'b0; // R7
      end else if (rd_lo) begin
        lock_ff <= 1'b1; // R7 R8
      end
    end
  end

  // Edge memory, vector acknowledge and pin synchronisers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trig_ff        <= 1'b0;
      ack_ff         <= 1'b0;
      pin_s1_ff      <= 11'h000;
      pin_s2_ff      <= 11'h000;
      done_prev_ff   <= 1'b0;
    end else begin
      trig_ff        <= src_raw; // R22
      ack_ff         <= irq_ack && irq_req;
      pin_s1_ff      <= pin_in;
      pin_s2_ff      <= pin_s1_ff;
      done_prev_ff   <= cs_ff[CS_DONE]; // R13
    end
  end

  // The port bits see zero for each disabled analog pin.
  assign pin_in_gated = pin_s2_ff &
                        ~{dh_ff[6:4], dl_ff}; // R16 R17

  // Read mux; unmapped addresses read zero.
  always_comb begin
    avs_readdata = 8'h00;
    unique case (req.address)
      ADDR_CTRL_STATUS: avs_readdata = cs_ff;
      ADDR_RES_LOW:     avs_readdata = res16[7:0];
      ADDR_RES_HIGH:    avs_readdata = res16[15:8];
      ADDR_TRIG_POL:    avs_readdata = tp_ff; // R15
      ADDR_DIS_LOW:     avs_readdata = dl_ff;
      ADDR_DIS_HIGH:    avs_readdata = dh_ff; // R15
      ADDR_MISC:        avs_readdata = ms_ff; // R15
      ADDR_MUX_CFG:     avs_readdata = mx_ff;
      default:          avs_readdata = 8'h00;
    endcase
  end

  assign irq_req = cs_ff[CS_DONE] && cs_ff[CS_IRQ_EN] &&
                   global_irq_en; // R3
  assign conv_sample = conv_end;
  assign ext_ref_sel = ms_ff[MS_EXTREF]; // R18
  assign ref_out_en  = ms_ff[MS_REFOUT]; // R19
  assign isrc_en     = ms_ff[MS_ISRC];
  assign conv_power  = enable; // R21
endmodule

// >>> verif/adcc_top_sva.sv
`timescale 1ns/1ps
module adcc_top_sva
  import adcc_pkg::*;
(
  input wire logic        core_clk,        // Clock.
  input wire logic        rst_n,           // Reset.
  input wire logic [3:0]  avs_address,     // Address.
  input wire logic        avs_read,        // Read.
  input wire logic        avs_write,       // Write.
  input wire logic [7:0]  avs_writedata,   // Write data.
  input wire logic [7:0]  avs_readdata,    // Read data.
  input wire logic        global_irq_en,   // Global enable.
  input wire logic        irq_req,         // Interrupt.
  input wire logic        conv_sample,     // Result capture.
  input wire logic        conv_clk_en,     // Converter tick.
  input wire logic [10:0] pin_in_gated,    // Gated pins.
  input wire logic        ext_ref_sel,     // Pin reference.
  input wire logic        ref_out_en,      // Reference out.
  input wire logic        conv_power       // Powered.
);
  // All checks share the one clock and its reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(logic [3:0] a);
    avs_write && avs_address == a;
  endsequence
  AST_PWR: assert property (s_wr(ADDR_CTRL_STATUS) |=>
    conv_power == $past(avs_writedata[CS_ENABLE])) else $error("power");
  AST_EXT: assert property (s_wr(ADDR_MISC) |=>
    ext_ref_sel == $past(avs_writedata[MS_EXTREF])) else $error("extref");
  AST_REFO: assert property (s_wr(ADDR_MISC) |=>
    ref_out_en == $past(avs_writedata[MS_REFOUT])) else $error("refout");
  AST_IRQ: assert property (irq_req |-> global_irq_en)
    else $error("irq without global enable");
  AST_RSV: assert property (avs_read && avs_address == ADDR_MISC |->
    avs_readdata[7:3] == 5'h00) else $error("reserved bits");
  AST_PIN: assert property (avs_read && avs_address == ADDR_DIS_LOW |->
    (pin_in_gated[7:0] & avs_readdata) == 8'h00) else $error("pin gate");
  AST_GAP: assert property (conv_clk_en |=> !conv_clk_en)
    else $error("tick gap");
  AST_SMP: assert property (conv_sample |-> conv_power)
    else $error("sample unpowered");
endmodule

bind adcc_top adcc_top_sva u_adcc_top_sva (.core_clk(core_clk),
  .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .global_irq_en(global_irq_en),
  .irq_req(irq_req), .conv_sample(conv_sample), .conv_clk_en(conv_clk_en),
  .pin_in_gated(pin_in_gated), .ext_ref_sel(ext_ref_sel),
  .ref_out_en(ref_out_en), .conv_power(conv_power));

// >>> verif/adcc_top_bench.sv
`timescale 1ns/1ps
module adcc_top_bench;
  import adcc_pkg::*;
  logic        core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        global_irq_en, irq_ack, irq_req, core_negative;
  logic        conv_sample, conv_clk_en, ext_ref_sel, ref_out_en;
  logic        isrc_en, conv_power;
  logic [3:0]  avs_address;
  logic [7:0]  avs_writedata, avs_readdata, trig_flags, d;
  logic [9:0]  core_data;
  logic [10:0] pin_in, pin_in_gated;
  logic [15:0] e;
  logic [31:0] seed;
  logic [7:0]  mdl [8];
  int          fails, compares, k;

  adcc_top u_adcc_top (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trig_flags(trig_flags),
    .global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq_req(irq_req),
    .conv_sample(conv_sample), .conv_clk_en(conv_clk_en),
    .core_data(core_data), .core_negative(core_negative),
    .pin_in(pin_in), .pin_in_gated(pin_in_gated),
    .ext_ref_sel(ext_ref_sel), .ref_out_en(ref_out_en),
    .isrc_en(isrc_en), .conv_power(conv_power));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] msk(input int a);
    return a == 3 ? TP_WMASK : a == 5 ? DH_WMASK : a == 6 ? MS_WMASK : 8'hff;
  endfunction
  task automatic chk(input string n, input logic [15:0] x, logic [15:0] g);
    compares++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  // One Avalon access; read data is taken at the edge that accepts it.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= v;
    if (w && a < 4'h8) mdl[a[2:0]] = v & msk(a);
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Counts ticks to the end of a conversion and checks the first spacing.
  task automatic run_conv(input int dv, input int nt);
    int t, last, n;
    n = 0;
    last = 0;
    for (t = 0; t < 5000; t++) begin
      @(negedge core_clk);
      if (conv_clk_en === 1'b1) begin
        if (n == 1) chk("tick gap", dv[15:0], t[15:0] - last[15:0]);
        last = t;
        n++;
      end
      if (conv_sample === 1'b1) break;
    end
    chk("tick count", nt[15:0], n[15:0]);
  endtask
  task automatic quiet(input string nm);
    int n;
    n = 0;
    repeat (200) begin
      @(negedge core_clk);
      if (conv_clk_en !== 1'b0) n++;
    end
    chk(nm, 16'h0, n[15:0]);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // A hang counts as a mismatch; the tests need under 10k cycles.
  initial begin
    #300000;
    fails++;
    report_and_stop;
  end
  // Main sequence.
  initial begin
    {rst_n, avs_read, avs_write, global_irq_en, irq_ack} = 5'h0;
    {avs_address, avs_writedata, trig_flags, core_negative} = 21'h0;
    {core_data, pin_in, fails, compares} = 85'h0;
    seed = 32'ha531;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 9; k++) begin
      bus(1'b0, k[3:0], 8'h00);
      chk("reset value", 16'h0, {8'h00, d});
    end
    for (k = 3; k < 8; k++) begin
      seed = lfsr(seed);
      bus(1'b1, k[3:0], seed[7:0]);
      bus(1'b0, k[3:0], 8'h00);
      chk("readback", {8'h00, mdl[k]}, {8'h00, d});
    end
    pin_in <= seed[18:8];
    repeat (4) @(negedge core_clk);
    chk("pins", {5'h0, pin_in & ~{mdl[5][6:4], mdl[4]}}, {5'h0, pin_in_gated});
    chk("refs", {13'h0, mdl[6][2:0]}, {13'h0, ext_ref_sel, ref_out_en, isrc_en});
    // Every divider code, both alignments, saturation and bipolar.
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      core_data <= seed[9:0];
      core_negative <= (k == 2);
      bus(1'b1, ADDR_MUX_CFG, {2'b00, k[0], 5'h00});
      bus(1'b1, ADDR_TRIG_POL, {k == 5, 7'h00});
      bus(1'b1, ADDR_CTRL_STATUS, 8'hd0 | k[7:0]);
      run_conv(k < 2 ? 2 : 1 << k, k == 0 ? 25 : 13);
      bus(1'b0, ADDR_CTRL_STATUS, 8'h00);
      chk("done start", 16'h0010, {8'h00, d & 8'h50});
      e = (k == 2) ? 16'h03ff : {6'h00, seed[9:0]};
      if (k[0]) e = e << 6;
      bus(1'b0, ADDR_RES_LOW, 8'h00);
      chk("result low", {8'h00, e[7:0]}, {8'h00, d});
      bus(1'b0, ADDR_RES_HIGH, 8'h00);
      chk("result high", {8'h00, e[15:8]}, {8'h00, d});
    end
    global_irq_en <= 1'b1;
    bus(1'b1, ADDR_CTRL_STATUS, 8'h8f);
    @(negedge core_clk);
    chk("irq on", 16'h1, {15'h0, irq_req});
    @(posedge core_clk);
    global_irq_en <= 1'b0;
    @(negedge core_clk);
    chk("irq masked", 16'h0, {15'h0, irq_req});
    @(posedge core_clk);
    global_irq_en <= 1'b1;
    irq_ack <= 1'b1;
    @(posedge core_clk);
    irq_ack <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("irq acked", 16'h0, {15'h0, irq_req});
    // A low-byte read holds the pair against a newer result.
    bus(1'b0, ADDR_RES_LOW, 8'h00);
    core_data <= ~seed[9:0];
    bus(1'b1, ADDR_CTRL_STATUS, 8'hd0);
    run_conv(2, 13);
    bus(1'b0, ADDR_RES_HIGH, 8'h00);
    chk("locked high", {8'h00, e[15:8]}, {8'h00, d});
    for (k = 1; k < 8; k++) begin
      bus(1'b1, ADDR_TRIG_POL, k[7:0]);
      bus(1'b1, ADDR_CTRL_STATUS, 8'hb0);
      trig_flags <= 8'h01 << k;
      run_conv(2, 13);
      quiet("one start");
      @(posedge core_clk);
      trig_flags <= 8'h00;
    end
    bus(1'b1, ADDR_TRIG_POL, 8'h02);
    trig_flags <= 8'h20;
    bus(1'b1, ADDR_TRIG_POL, 8'h05);
    run_conv(2, 13);
    bus(1'b1, ADDR_TRIG_POL, 8'h00);
    quiet("free switch");
    bus(1'b1, ADDR_CTRL_STATUS, 8'h90);
    bus(1'b1, ADDR_TRIG_POL, 8'h01);
    trig_flags <= 8'h02;
    quiet("auto off");
    bus(1'b1, ADDR_CTRL_STATUS, 8'hc7);
    repeat (20) @(posedge core_clk);
    bus(1'b1, ADDR_CTRL_STATUS, 8'h00);
    quiet("aborted");
    bus(1'b0, ADDR_CTRL_STATUS, 8'h00);
    chk("start cleared", 16'h0, {8'h00, d & 8'h40});
    report_and_stop;
  end
endmodule
